// ### src/hdr_responder.sv
`timescale 1ns/1ps
`include "hdr_defines.svh"

// Contract
// - Interface descriptor: 9 bytes, type 04h, class 09h, subclass/protocol 00h.
// - Interface number and alternate setting both read 00h.
// - Interface declares one endpoint beyond endpoint zero.
// - Interface string index is always 00h.
// - Endpoint descriptor: 7 bytes, type 05h.
// - Endpoint address byte is 81h, IN endpoint one.
// - Endpoint attributes byte is 03h, interrupt, no sync.
// - Endpoint max packet size is 0001h, one byte.
// - Endpoint polling interval byte is FFh.
// - Hub descriptor answered for type 29h and legacy 00h.
// - Hub descriptor 9 bytes, type 29h, same at both speeds.
// - Port count is three minus disabled ports in active mask.
// - Self-powered select picks self-powered mask, else bus-powered mask.
// - Characteristics bits 1:0 are 00 or 01 from power switching.
// - Bit 2 is compound setting; bits 4:3 are sense mode.
// - Characteristics bits 6:5 are 00, eight bit times.
// - Bit 7 and bits 15:8 are zero.
// - Power-on-to-good byte is stored power-on time unchanged.
// - Variable fields come from default load or config port load.
module hdr_responder #(
	parameter logic [2:0] DEF_OFF_BP = 3'h0,
	parameter logic [2:0] DEF_OFF_SP = 3'h0,
	parameter logic DEF_SELF = 1'b0,
	parameter logic DEF_PPS = 1'b1,
	parameter logic DEF_COMPOUND = 1'b0,
	parameter logic [1:0] DEF_SENSE = 2'h1,
	parameter logic [7:0] DEF_PON_TIME = 8'h32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Descriptor request
	input wire hdr_pkg::hdr_req_t req,
	output logic req_ready,
	output logic req_stall,
	// Descriptor bytes
	output hdr_pkg::hdr_byte_t tx
);
	import hdr_pkg::*;

	hdr_st_t s;
	hdr_st_t next_s;
	logic [2:0] off_mask;
	logic [1:0] nports;
	logic [3:0] dlen;
	hdr_kind_t rkind;
	logic rok;
	logic wb_req;
	logic cfg_wr;

	assign off_mask = s.cfg.self_powered_select ? s.cfg.port_off_mask_self_powered
		: s.cfg.port_off_mask_bus_powered;
	// port count
	// Two-bit result, no wrap: all three ports off reports zero
	assign nports = `HDR_PORTS_TOTAL - 2'(off_mask[0]) - 2'(off_mask[1]) - 2'(off_mask[2]);
	assign wb_req = wb_cyc_i && wb_stb_i && !s.wb_ack;
	assign cfg_wr = wb_req && wb_we_i && (wb_adr_i == `HDR_REG_CFG);

	function automatic logic [7:0] hdr_byte(input hdr_kind_t k, input logic [3:0] i,
		input hdr_cfg_t c, input logic [1:0] np);
		logic [7:0] b;
		b = 8'h00;
		case (k)
			HDR_KIND_IF:
			begin
				case (i)
					4'h0: b = 8'(`HDR_LEN_IF);
					4'h1: b = `HDR_TYPE_IF;
					4'h4: b = `HDR_IF_ONE_EP;
					4'h5: b = `HDR_IF_CLASS;
					default: b = 8'h00;
				endcase
			end
			HDR_KIND_EP:
			begin
				case (i)
					4'h0: b = 8'(`HDR_LEN_EP);
					4'h1: b = `HDR_TYPE_EP;
					4'h2: b = `HDR_EP_ADDR;
					4'h3: b = `HDR_EP_ATTR;
					4'h4: b = `HDR_EP_MPS_LO;
					4'h6: b = `HDR_EP_IVAL;
					default: b = 8'h00;
				endcase
			end
			HDR_KIND_HUB:
			begin
				case (i)
					4'h0: b = 8'(`HDR_LEN_HUB);
					4'h1: b = `HDR_TYPE_HUB;
					4'h2: b = {6'h00, np};
					4'h3: b = {3'h0, c.overcurrent_sense_mode, c.compound, 1'b0,
						c.per_port_power_switching};
					4'h5: b = c.power_on_time;
					4'h8: b = `HDR_HUB_PWR_MASK;
					default: b = 8'h00;
				endcase
			end
			default: b = 8'h00;
		endcase
		return b;
	endfunction : hdr_byte

	always_comb
	begin
		rok = 1'b1;
		rkind = HDR_KIND_HUB;
		dlen = `HDR_LEN_HUB;
		case (req.dtype)
			`HDR_TYPE_IF:
			begin
				rkind = HDR_KIND_IF;
				dlen = `HDR_LEN_IF;
			end
			`HDR_TYPE_EP:
			begin
				rkind = HDR_KIND_EP;
				dlen = `HDR_LEN_EP;
			end
			`HDR_TYPE_HUB, `HDR_TYPE_HUB_OLD: rkind = HDR_KIND_HUB;
			default: rok = 1'b0;
		endcase
	end

	always_comb
	begin
		next_s = s;
		next_s.tx = '0;
		next_s.req_stall = 1'b0;
		next_s.wb_ack = wb_req;
		next_s.wb_dat = 32'h0;
		case (s.state)
			HDR_IDLE:
			begin
				if (req.valid && !rok)
				begin
					next_s.req_stall = 1'b1;
				end
				else if (req.valid)
				begin
					next_s.kind = rkind;
					next_s.idx = 4'h0;
					next_s.limit = (req.len < 16'(dlen)) ? req.len[3:0] : dlen;
					if (req.len != 16'h0)
					begin
						next_s.state = HDR_SEND;
					end
				end
			end
			HDR_SEND:
			begin
				next_s.tx.valid = 1'b1;
				next_s.tx.data = hdr_byte(s.kind, s.idx, s.cfg, nports);
				next_s.tx.last = (s.idx == s.limit - 4'h1);
				next_s.okind = s.kind;
				next_s.oidx = s.idx;
				next_s.idx = s.idx + 4'h1;
				if (next_s.tx.last)
				begin
					next_s.state = HDR_IDLE;
				end
			end
			default: next_s.state = HDR_IDLE;
		endcase
		next_s.req_ready = (next_s.state == HDR_IDLE);
		// Unmapped reads return zero; writes there are dropped but acked
		if (cfg_wr)
		begin
			if (wb_sel_i[0])
			begin
				next_s.cfg[7:0] = wb_dat_i[7:0];
			end
			if (wb_sel_i[1])
			begin
				next_s.cfg[10:8] = wb_dat_i[10:8];
			end
			if (wb_sel_i[2])
			begin
				next_s.cfg.power_on_time = wb_dat_i[23:16];
			end
		end
		if (wb_req && !wb_we_i)
		begin
			case (wb_adr_i)
				`HDR_REG_CFG: next_s.wb_dat = {8'h00, s.cfg[18:11], 5'h00, s.cfg[10:0]};
				`HDR_REG_STAT: next_s.wb_dat = {27'h0, s.state == HDR_SEND, 2'h0, nports};
				default: next_s.wb_dat = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			s <= '0;
			s.state <= HDR_IDLE;
			s.req_ready <= 1'b1;
			s.cfg <= '{DEF_PON_TIME, DEF_SENSE, DEF_COMPOUND, DEF_PPS, DEF_SELF,
				DEF_OFF_SP, DEF_OFF_BP};
		end
		else
		begin
			s <= next_s;
		end
	end

	assign tx = s.tx;
	assign req_ready = s.req_ready;
	assign req_stall = s.req_stall;
	assign wb_ack_o = s.wb_ack;
	assign wb_dat_o = s.wb_dat;

	property p_if_head;
		@(posedge clk) disable iff (sys_rst)
		tx.valid && s.okind == HDR_KIND_IF |-> (s.oidx == 4'h0 ? tx.data == 8'h09
			: s.oidx == 4'h1 ? tx.data == 8'h04 : s.oidx == 4'h5 ? tx.data == 8'h09 : 1'b1);
	endproperty
	a_if_head: assert property (p_if_head) else $error("bad interface header");

	property p_if_zero;
		@(posedge clk) disable iff (sys_rst)
		tx.valid && s.okind == HDR_KIND_IF && (s.oidx inside {4'h2, 4'h3, 4'h6, 4'h7, 4'h8})
			|-> tx.data == 8'h00;
	endproperty
	a_if_zero: assert property (p_if_zero) else $error("interface zero byte not zero");

	property p_if_nep;
		@(posedge clk) disable iff (sys_rst)
		tx.valid && s.okind == HDR_KIND_IF && s.oidx == 4'h4 |-> tx.data == 8'h01;
	endproperty
	a_if_nep: assert property (p_if_nep) else $error("endpoint count wrong");

	property p_ep_bytes;
		@(posedge clk) disable iff (sys_rst)
		tx.valid && s.okind == HDR_KIND_EP |-> tx.data == (s.oidx == 4'h0 ? 8'h07
			: s.oidx == 4'h1 ? 8'h05 : s.oidx == 4'h2 ? 8'h81 : s.oidx == 4'h3 ? 8'h03
			: s.oidx == 4'h4 ? 8'h01 : s.oidx == 4'h6 ? 8'hFF : 8'h00);
	endproperty
	a_ep_bytes: assert property (p_ep_bytes) else $error("endpoint byte wrong");

	property p_hub_chars;
		@(posedge clk) disable iff (sys_rst)
		tx.valid && s.okind == HDR_KIND_HUB && s.oidx == 4'h3 |-> tx.data[7:5] == 3'h0
			&& tx.data[1] == 1'b0 && tx.data[0] == $past(s.cfg.per_port_power_switching);
	endproperty
	a_hub_chars: assert property (p_hub_chars) else $error("hub characteristics wrong");

	property p_hub_pon;
		@(posedge clk) disable iff (sys_rst)
		tx.valid && s.okind == HDR_KIND_HUB && s.oidx == 4'h5
			|-> tx.data == $past(s.cfg.power_on_time);
	endproperty
	a_hub_pon: assert property (p_hub_pon) else $error("power-on time altered");

	property p_nports;
		@(posedge clk) disable iff (sys_rst)
		nports == 2'(3 - $countones(s.cfg.self_powered_select
			? s.cfg.port_off_mask_self_powered : s.cfg.port_off_mask_bus_powered));
	endproperty
	a_nports: assert property (p_nports) else $error("port count wrong");

	property p_legacy;
		@(posedge clk) disable iff (sys_rst)
		req.valid && req_ready && req.dtype == 8'h00 && req.len != 16'h0
			|=> ##1 tx.valid && tx.data == 8'h09;
	endproperty
	a_legacy: assert property (p_legacy) else $error("legacy hub type ignored");

	property p_stop;
		@(posedge clk) disable iff (sys_rst)
		tx.valid && tx.last |=> !tx.valid;
	endproperty
	a_stop: assert property (p_stop) else $error("byte after last");

	property p_order;
		@(posedge clk) disable iff (sys_rst)
		tx.valid && !tx.last |=> tx.valid && s.oidx == $past(s.oidx) + 4'h1;
	endproperty
	a_order: assert property (p_order) else $error("bytes out of order");

	property p_if_str;
		@(posedge clk) disable iff (sys_rst)
		tx.valid && s.okind == HDR_KIND_IF && s.oidx == 4'h8 |-> tx.data == 8'h00;
	endproperty
	a_if_str: assert property (p_if_str) else $error("interface string index not zero");

	property p_hub_head;
		@(posedge clk) disable iff (sys_rst)
		tx.valid && s.okind == HDR_KIND_HUB && s.oidx < 4'h2
			|-> tx.data == (s.oidx == 4'h0 ? 8'h09 : 8'h29);
	endproperty
	a_hub_head: assert property (p_hub_head) else $error("hub header wrong");

	// Live config: compare against what was stored when the byte was built
	property p_hub_sense;
		@(posedge clk) disable iff (sys_rst)
		tx.valid && s.okind == HDR_KIND_HUB && s.oidx == 4'h3
			|-> tx.data[4:3] == $past(s.cfg.overcurrent_sense_mode)
			&& tx.data[2] == $past(s.cfg.compound);
	endproperty
	a_hub_sense: assert property (p_hub_sense) else $error("sense or compound bit wrong");

	property p_hub_high;
		@(posedge clk) disable iff (sys_rst)
		tx.valid && s.okind == HDR_KIND_HUB && s.oidx == 4'h4 |-> tx.data == 8'h00;
	endproperty
	a_hub_high: assert property (p_hub_high) else $error("characteristics upper byte set");

	property p_cfg_hold;
		@(posedge clk) disable iff (sys_rst)
		!$past(sys_rst) && !$past(cfg_wr) |-> $stable(s.cfg);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without a load");

	c_if: cover property (@(posedge clk) tx.valid && tx.last && s.okind == HDR_KIND_IF);
	c_ep: cover property (@(posedge clk) tx.valid && tx.last && s.okind == HDR_KIND_EP);
	c_hub: cover property (@(posedge clk) tx.valid && tx.last && s.okind == HDR_KIND_HUB
		&& s.oidx == 4'h8);
	c_stall: cover property (@(posedge clk) req_stall);
	c_load: cover property (@(posedge clk) cfg_wr);

endmodule : hdr_responder

// ### src/hdr_defines.svh
`ifndef HDR_DEFINES_SVH
`define HDR_DEFINES_SVH

// Register byte offsets
`define HDR_REG_CFG 8'h00
`define HDR_REG_STAT 8'h04

// Config register fields
`define HDR_CFG_BP_LO 0
`define HDR_CFG_SP_LO 3
`define HDR_CFG_SELF 6
`define HDR_CFG_PPS 7
`define HDR_CFG_COMP 8
`define HDR_CFG_SNS_LO 9
`define HDR_CFG_PON_LO 16

// Status register fields
`define HDR_STAT_NPORT_LO 0
`define HDR_STAT_BUSY 4

// Descriptor type codes
`define HDR_TYPE_IF 8'h04
`define HDR_TYPE_EP 8'h05
`define HDR_TYPE_HUB 8'h29
`define HDR_TYPE_HUB_OLD 8'h00

// Descriptor lengths
`define HDR_LEN_IF 4'h9
`define HDR_LEN_EP 4'h7
`define HDR_LEN_HUB 4'h9

// Fixed field values
`define HDR_IF_CLASS 8'h09
`define HDR_IF_ONE_EP 8'h01
`define HDR_EP_ADDR 8'h81
`define HDR_EP_ATTR 8'h03
`define HDR_EP_MPS_LO 8'h01
`define HDR_EP_IVAL 8'hFF
`define HDR_HUB_PWR_MASK 8'hFF
`define HDR_PORTS_TOTAL 2'h3

`endif

// ### src/hdr_pkg.sv
package hdr_pkg;

	typedef enum logic [1:0] {HDR_KIND_IF, HDR_KIND_EP, HDR_KIND_HUB} hdr_kind_t;

	typedef enum logic {HDR_IDLE, HDR_SEND} hdr_state_t;

	// Configuration values as loaded by default or over the config port
	typedef struct packed {
		logic [7:0] power_on_time;
		logic [1:0] overcurrent_sense_mode;
		logic compound;
		logic per_port_power_switching;
		logic self_powered_select;
		logic [2:0] port_off_mask_self_powered;
		logic [2:0] port_off_mask_bus_powered;
	} hdr_cfg_t;

	// Descriptor request from the control endpoint
	typedef struct packed {
		logic valid;
		logic [7:0] dtype;
		logic [15:0] len;
	} hdr_req_t;

	// Descriptor byte stream
	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic last;
	} hdr_byte_t;

	typedef struct packed {
		hdr_state_t state;
		hdr_kind_t kind;
		logic [3:0] idx;
		logic [3:0] limit;
		hdr_kind_t okind;
		logic [3:0] oidx;
		hdr_byte_t tx;
		logic req_ready;
		logic req_stall;
		hdr_cfg_t cfg;
		logic wb_ack;
		logic [31:0] wb_dat;
	} hdr_st_t;

endpackage : hdr_pkg

// ### tb/hdr_host_model.sv
`timescale 1ns/1ps
module hdr_host_model (
	// Clock
	input wire logic clk,
	// Request handshake
	input wire logic req_ready,
	output hdr_pkg::hdr_req_t req
);
	import hdr_pkg::*;

	initial req = '0;

	// Idle gap first, then hold until taken; fields scrambled once released
	task automatic request(input logic [7:0] t, input logic [15:0] len, input int gap,
		output logic taken);
		int n;
		taken = 1'b0;
		repeat (gap + 1) @(posedge clk);
		req <= '{valid: 1'b1, dtype: t, len: len};
		for (n = 0; n < 50 && !taken; n++)
		begin
			@(posedge clk);
			taken = (req_ready === 1'b1);
		end
		req <= '{valid: 1'b0, dtype: ~t, len: ~len};
	endtask : request
endmodule : hdr_host_model

// ### tb/hub_descriptor_responder_test.sv
`timescale 1ns/1ps
module hub_descriptor_responder_test;
	import hdr_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = '0;
	logic [3:0] wb_sel_i = '0;
	logic [31:0] wb_dat_i = '0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	hdr_req_t req;
	logic req_ready;
	logic req_stall;
	hdr_byte_t tx;
	logic [9:0] exp_q[$];
	logic [31:0] cfg = 32'h00320280;
	logic [31:0] seed = 32'hD02753CE;
	logic [31:0] rd;
	logic [7:0] types[8] = '{8'h04, 8'h05, 8'h29, 8'h00, 8'h01, 8'h02, 8'h03, 8'hFF};
	logic [15:0] lens[4] = '{16'h0000, 16'h0001, 16'h0005, 16'h0100};
	int num_errors = 0;
	int n_compared = 0;

	hdr_responder hdr_responder_inst (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req(req),
		.req_ready(req_ready), .req_stall(req_stall), .tx(tx));
	hdr_host_model hdr_host_model_inst (.clk(clk), .req_ready(req_ready), .req(req));

	initial
	begin
		forever #2.5 clk = ~clk;
	end

	task automatic final_report;
		if (num_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic fail;
		num_errors++;
		final_report();
	endtask : fail

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic logic [1:0] nports(input logic [31:0] c);
		logic [2:0] m;
		m = c[6] ? c[5:3] : c[2:0];
		return 2'(3 - m[0] - m[1] - m[2]);
	endfunction : nports

	// Stall noted as bit 9; bytes as {last, data}
	always @(posedge clk)
	begin
		if (!sys_rst && (tx.valid !== 1'b0 || req_stall !== 1'b0))
		begin
			if (exp_q.size() == 0)
				check({req_stall, tx.last, tx.data}, '1);
			else
				check({req_stall, tx.last, tx.data}, exp_q.pop_front());
		end
	end

	task automatic ask(input logic [7:0] t, input logic [15:0] len, input int gap);
		logic [7:0] d[9];
		logic taken;
		int n;
		int k;
		n = (t == 8'h05) ? 7 : 9;
		d = '{8'h09, 8'h04, 8'h00, 8'h00, 8'h01, 8'h09, 8'h00, 8'h00, 8'h00};
		if (t == 8'h05)
			d = '{8'h07, 8'h05, 8'h81, 8'h03, 8'h01, 8'h00, 8'hFF, 8'h00, 8'h00};
		if (t == 8'h29 || t == 8'h00)
			d = '{8'h09, 8'h29, {6'h0, nports(cfg)}, {3'h0, cfg[10:8], 1'b0, cfg[7]},
				8'h00, cfg[23:16], 8'h00, 8'h00, 8'hFF};
		if (len < 16'(n))
			n = int'(len);
		if (!(t inside {8'h04, 8'h05, 8'h29, 8'h00}))
			exp_q.push_back(10'h200);
		else
			for (k = 0; k < n; k++)
				exp_q.push_back({1'b0, k == n - 1, d[k]});
		hdr_host_model_inst.request(t, len, gap, taken);
		if (!taken)
			fail();
		for (k = 0; k < 40 && (exp_q.size() != 0 || req_ready !== 1'b1); k++)
			@(posedge clk);
		if (k == 40)
			fail();
	endtask : ask

	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int k;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hF;
		wb_dat_i <= dat;
		for (k = 0; k < 20 && wb_ack_o !== 1'b1; k++)
			@(posedge clk);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (k == 20)
			fail();
	endtask : wb

	task automatic set_cfg(input logic [31:0] v);
		wb(1'b1, 8'h00, v);
		cfg = v & 32'h00FF07FF;
		wb(1'b0, 8'h00, '0);
		check(rd, cfg);
		wb(1'b0, 8'h04, '0);
		check(rd, {30'h0, nports(cfg)});
	endtask : set_cfg

	initial
	begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		for (int t = 0; t < 8; t++)
			for (int l = 0; l < 4; l++)
				ask(types[t], lens[l], l);
		set_cfg(32'h001107E8);
		ask(8'h00, 16'h0009, 0);
		for (int r = 0; r < 8; r++)
		begin
			seed = lfsr(seed);
			set_cfg(seed);
			ask(r[0] ? 8'h29 : 8'h00, {12'h0, seed[27:24]}, int'(seed[29:28]));
		end
		// Unmapped place: write lost, read zero
		wb(1'b1, 8'h08, '1);
		wb(1'b0, 8'h08, '0);
		check(rd, 32'h0);
		wb(1'b0, 8'h00, '0);
		check(rd, cfg);
		final_report();
	end
endmodule : hub_descriptor_responder_test
